// ---- hdl/sbc_consts.svh ----
// Constants of the serial bus control block: offsets, bit positions,
// reset values and timing counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
`define SBC_ADDR_W      10
`define SBC_OFS_CTRL    10'h288
`define SBC_OFS_STAT    10'h28C
`define SBC_CTRL_RESET  8'h00
`define SBC_B_ON        7
`define SBC_B_GATE      6
`define SBC_B_MSEL      5
`define SBC_B_TSEL      4
`define SBC_B_ACKS      3
`define SBC_B_REPEAT_START_REQUEST      2
`define SBC_S_ICF       7
`define SBC_S_AAS       6
`define SBC_S_BUSY      5
`define SBC_S_AL        4
`define SBC_S_SRW       2
`define SBC_S_IIF       1
`define SBC_CLK_MHZ     25
`define SBC_T_COND_NS   160
`define SBC_T_COND_CYC  ((`SBC_T_COND_NS * `SBC_CLK_MHZ + 999) / 1000)
// Start check waits out the pin synchroniser lag as well
`define SBC_T_CHK_CYC   (`SBC_T_COND_CYC + 2)
`define SBC_FALL_FIRST  4'h1
`define SBC_FALL_BIT1   4'h2
`define SBC_FALL_ACK    4'h9
`define SBC_FALL_DONE   4'hA
`endif

// ---- hdl/sbc_pkg.sv ----
// Types of the serial bus control block: state encodings and the packed
// state records of each module.
// Assumes nothing beyond a SystemVerilog compiler.
package sbc_pkg;
   // Condition generator states, one-hot
   typedef enum logic [6:0] {
      GEN_IDLE    = 7'h01,
      GEN_ST_CHK  = 7'h02,
      GEN_ST_FALL = 7'h04,
      GEN_OWN     = 7'h08,
      GEN_SP_LOW  = 7'h10,
      GEN_SP_RISE = 7'h20,
      GEN_RS_REL  = 7'h40
   } sbc_gen_e;

   typedef struct packed {
      sbc_gen_e   st;      // Sequence state
      logic [7:0] tmr;     // Condition timer
      logic       scl_oe;  // Clock line pulled low
      logic       sda_oe;  // Data line pulled low
      logic       lost;    // Arbitration lost pulse
      logic       owned;   // Bus held as master
   } sbc_gen_s;

   typedef struct packed {
      logic s1;    // First stage, read only by s2
      logic s2;
      logic s3;
      logic filt;  // Accepted level
   } sbc_sync_s;

   typedef struct packed {
      logic       on;         // Controller enable
      logic       gate;       // Interrupt gate
      logic       msel;       // Master select
      logic       tsel;       // Transmit select
      logic       acks;       // Acknowledge suppress
      logic [7:0] rd_data;    // Read answer
      logic       irq;        // Interrupt request
      logic       busy;       // Bus occupied flag
      logic       irq_pending_flag;        // Interrupt pending flag
      logic       aas;        // Addressed as slave flag
      logic       al;         // Arbitration lost flag
      logic       slave_direction_flag;        // Slave direction flag
      logic       icf;        // Byte complete flag
      logic       synced;     // Start seen since enable or last STOP
      logic [3:0] cnt;        // Clock falls in current byte
      logic       scl_p;      // Previous filtered clock
      logic       sda_p;      // Previous filtered data
      logic       ack_low;    // Acknowledge drive request
      logic       cmd_start;  // Generator commands
      logic       cmd_stop;
      logic       cmd_rstart;
      logic       pin_lo;     // Open-drain low level
   } sbc_top_s;
endpackage

// ---- hdl/sbc_sync.sv ----
// Three-stage input synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clock and idles high.
`timescale 1ns/10ps
`default_nettype none
module sbc_sync (
   input  wire logic clock,  // System clock
   input  wire logic rst,    // Asynchronous reset
   input  wire logic pin,    // Raw pin level
   output logic      level   // Filtered level
);
   sbc_pkg::sbc_sync_s q;  // Registered state
   sbc_pkg::sbc_sync_s d;  // Next state

   // Shift in; accept a change only once stages two and three agree
   always_comb begin
      d      = q;
      d.s1   = pin;
      d.s2   = q.s1;
      d.s3   = q.s2;
      d.filt = (q.s2 == q.s3) ? q.s3 : q.filt;
   end

   // Idle-high reset keeps the bus monitor from seeing false edges
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q <= 4'hF;
      end else begin
         q <= d;
      end
   end

   assign level = q.filt;
endmodule
`default_nettype wire

// ---- hdl/sbc_cond_gen.sv ----
// Bus condition generator: START, STOP and repeated START waveforms,
// plus the acknowledge pull-down, on open-drain clock and data lines.
// Assumes filtered pin levels on the same clock and pulse commands.
`include "sbc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sbc_cond_gen (
   input  wire logic clock,       // System clock
   input  wire logic rst,         // Asynchronous reset
   input  wire logic clear,       // Soft reset while disabled
   input  wire logic cmd_start,   // Issue START
   input  wire logic cmd_stop,    // Issue STOP
   input  wire logic cmd_rstart,  // Issue repeated START
   input  wire logic ack_low,     // Pull data low for acknowledge
   input  wire logic scl_f,       // Filtered clock line
   input  wire logic sda_f,       // Filtered data line
   output logic      scl_oe,      // Clock line pulled low
   output logic      sda_oe,      // Data line pulled low
   output logic      lost,        // Arbitration lost, one cycle
   output logic      owned        // Bus held as master
);
   localparam sbc_pkg::sbc_gen_s RST_VAL = '{st: sbc_pkg::GEN_IDLE, default: '0};

   sbc_pkg::sbc_gen_s q;  // Registered state
   sbc_pkg::sbc_gen_s d;  // Next state
   logic              done;     // Condition time elapsed
   logic              chk_due;  // Line check time reached

   // Sequence the lines; each timed step holds for the condition time, the start check for two cycles more
   always_comb begin
      d      = q;
      d.lost = 1'b0;
      d.tmr  = q.tmr + 8'h01;
      done   = (q.tmr == 8'(`SBC_T_COND_CYC - 1));
      chk_due = (q.tmr == 8'(`SBC_T_CHK_CYC - 1));
      case (q.st)
         sbc_pkg::GEN_IDLE: begin
            d.tmr    = 8'h00;
            d.scl_oe = 1'b0;
            d.sda_oe = ack_low;  // R13
            if (cmd_start) begin
               d.st     = sbc_pkg::GEN_ST_CHK;  // R10
               d.sda_oe = 1'b0;
            end
         end
         sbc_pkg::GEN_ST_CHK: begin
            // Checked past the sync lag: a just-released clock would fake a collision
            if (chk_due) begin
               d.tmr = 8'h00;
               if (!scl_f || !sda_f) begin
                  d.lost = 1'b1;  // R3
                  d.st   = sbc_pkg::GEN_IDLE;
               end else begin
                  d.sda_oe = 1'b1;
                  d.st     = sbc_pkg::GEN_ST_FALL;
               end
            end
         end
         sbc_pkg::GEN_ST_FALL: begin
            if (done) begin
               d.tmr    = 8'h00;
               d.scl_oe = 1'b1;
               d.st     = sbc_pkg::GEN_OWN;
            end
         end
         sbc_pkg::GEN_OWN: begin
            // Clock held low until a STOP or repeated START command moves on
            d.tmr = 8'h00;
            if (cmd_stop) begin
               d.sda_oe = 1'b1;  // R9
               d.st     = sbc_pkg::GEN_SP_LOW;
            end else if (cmd_rstart) begin
               d.sda_oe = 1'b0;  // R15
               d.st     = sbc_pkg::GEN_RS_REL;
            end
         end
         sbc_pkg::GEN_SP_LOW: begin
            if (done) begin
               d.tmr    = 8'h00;
               d.scl_oe = 1'b0;
               d.st     = sbc_pkg::GEN_SP_RISE;
            end
         end
         sbc_pkg::GEN_SP_RISE: begin
            if (done) begin
               d.tmr    = 8'h00;
               d.sda_oe = 1'b0;
               d.st     = sbc_pkg::GEN_IDLE;
            end
         end
         sbc_pkg::GEN_RS_REL: begin
            if (done) begin
               d.tmr    = 8'h00;
               d.scl_oe = 1'b0;
               d.st     = sbc_pkg::GEN_ST_CHK;
            end
         end
         default: begin
            d = RST_VAL;
         end
      endcase
      d.owned = (d.st == sbc_pkg::GEN_OWN);
      if (clear) begin
         d = RST_VAL;  // R1
      end
   end

   // State register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q <= RST_VAL;
      end else begin
         q <= d;
      end
   end

   assign scl_oe = q.scl_oe;
   assign sda_oe = q.sda_oe;
   assign lost   = q.lost;
   assign owned  = q.owned;
endmodule
`default_nettype wire

// ---- hdl/sbc_ctrl.sv ----
// Serial bus control block: control and status registers, bus monitor,
// byte clock counting, interrupt gating and mode-change commands.
// Assumes a same-clock register port, an address matcher on the same
// clock, and open-drain clock and data pins with external pull-ups.
//
// Function
// R1: Enable bit zero holds controller in reset
// R2: Slave waits for next START after enable
// R3: Master unaware of busy bus; collision loses; code also loses a START written while busy is set
// R4: Registers stay accessible while disabled
// R5: Other control fields inert while disabled
// R6: Interrupt needs gate and pending flag both
// R7: Clearing gate masks but keeps pending flag
// R8: Arbitration loss clears master select, no STOP
// R9: Master select one-to-zero issues STOP
// R10: Master select zero-to-one issues START
// R11: Transmit select sets transfer direction
// R12: Software picks direction from slave flag
// R13: Receiver acknowledges on ninth clock unless suppressed
// R14: Repeat start bit always reads zero
// R15: Repeat start write issues repeated START
// R16: Repeat start without bus ownership loses
// R17: Software writes zero to reserved bits
// R18: Control write clears addressed-as-slave flag
// R19: Pending flag set on byte, match, loss; code sets it on a match only for write direction
// R20: Busy set on START, cleared on STOP
// R21: Reset clears every control field
`include "sbc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sbc_ctrl (
   input  wire logic                   clock,    // System clock, 25 MHz
   input  wire logic                   rst,      // Asynchronous reset
   input  wire logic [`SBC_ADDR_W-1:0] addr,     // Register byte address
   input  wire logic [7:0]             wr_data,  // Write data
   input  wire logic                   wr_en,    // Write strobe
   input  wire logic                   rd_en,    // Read strobe
   output logic      [7:0]             rd_data,  // Read data, next cycle
   input  wire logic                   addr_hit, // Own address matched
   input  wire logic                   addr_rw,  // Direction bit of match
   input  wire logic                   scl_in,   // Clock line level
   output logic                        scl_out,  // Clock drive level
   output logic                        scl_oe,   // Clock line pulled low
   input  wire logic                   sda_in,   // Data line level
   output logic                        sda_out,  // Data drive level
   output logic                        sda_oe,   // Data line pulled low
   output logic                        irq       // Interrupt request
);
   sbc_pkg::sbc_top_s q;  // Registered state
   sbc_pkg::sbc_top_s d;  // Next state

   logic scl_f;      // Filtered clock line
   logic sda_f;      // Filtered data line
   logic gen_lost;   // Generator lost arbitration
   logic gen_owned;  // Generator holds the bus
   logic start_det;  // START seen on the bus
   logic stop_det;   // STOP seen on the bus
   logic scl_fall;   // Clock falling edge
   logic part;       // This controller takes part in the byte
   logic act;        // Write lands on an enabled controller
   logic [3:0] nxt;  // Next clock fall count

   // Pin synchronisers
   sbc_sync u_scl_sync (
      .clock (clock),
      .rst   (rst),
      .pin   (scl_in),
      .level (scl_f)
   );

   sbc_sync u_sda_sync (
      .clock (clock),
      .rst   (rst),
      .pin   (sda_in),
      .level (sda_f)
   );

   // Condition generator, cleared while disabled
   sbc_cond_gen u_gen (
      .clock      (clock),
      .rst        (rst),
      .clear      (~q.on),
      .cmd_start  (q.cmd_start),
      .cmd_stop   (q.cmd_stop),
      .cmd_rstart (q.cmd_rstart),
      .ack_low    (q.ack_low),
      .scl_f      (scl_f),
      .sda_f      (sda_f),
      .scl_oe     (scl_oe),
      .sda_oe     (sda_oe),
      .lost       (gen_lost),
      .owned      (gen_owned)
   );

   // Register access, bus monitor and flag updates
   always_comb begin
      d            = q;
      d.rd_data    = 8'h00;
      d.cmd_start  = 1'b0;
      d.cmd_stop   = 1'b0;
      d.cmd_rstart = 1'b0;
      d.pin_lo     = 1'b0;
      d.scl_p      = scl_f;
      d.sda_p      = sda_f;
      start_det    = q.scl_p & scl_f & q.sda_p & ~sda_f;
      stop_det     = q.scl_p & scl_f & ~q.sda_p & sda_f;
      scl_fall     = q.scl_p & ~scl_f;
      part         = q.msel | q.aas;
      act          = q.on & wr_data[`SBC_B_ON];
      nxt          = q.cnt + 4'h1;

      // Writes come first so that hardware sets below win over clears
      if (wr_en && (addr == `SBC_OFS_CTRL)) begin
         // Stored even while disabled, reserved bits dropped
         d.on   = wr_data[`SBC_B_ON];  // R4
         d.gate = wr_data[`SBC_B_GATE];  // R7
         d.msel = wr_data[`SBC_B_MSEL];
         d.tsel = wr_data[`SBC_B_TSEL];  // R11
         d.acks = wr_data[`SBC_B_ACKS];
         d.aas  = 1'b0;  // R18
         // Mode changes act only on an enabled controller
         if (act && !q.msel && wr_data[`SBC_B_MSEL]) begin
            if (q.busy) begin
               // Start attempted on a busy bus
               d.al   = 1'b1;
               d.irq_pending_flag  = 1'b1;
               d.msel = 1'b0;
            end else begin
               d.cmd_start = 1'b1;  // R10
            end
         end
         if (act && q.msel && !wr_data[`SBC_B_MSEL] && gen_owned) begin
            d.cmd_stop = 1'b1;  // R9
         end
         if (act && wr_data[`SBC_B_REPEAT_START_REQUEST]) begin
            if (gen_owned && wr_data[`SBC_B_MSEL]) begin
               d.cmd_rstart = 1'b1;  // R15
            end else begin
               d.al  = 1'b1;  // R16
               d.irq_pending_flag = 1'b1;
            end
         end
      end

      // Status write: zero clears pending and lost flags
      if (wr_en && (addr == `SBC_OFS_STAT)) begin
         if (!wr_data[`SBC_S_IIF]) begin
            d.irq_pending_flag = 1'b0;
         end
         if (!wr_data[`SBC_S_AL]) begin
            d.al = 1'b0;
         end
      end

      // Bus monitor
      if (start_det) begin
         d.busy    = 1'b1;  // R20
         d.synced  = 1'b1;  // R2
         d.cnt     = 4'h0;
         d.ack_low = 1'b0;
      end else if (stop_det) begin
         d.busy    = 1'b0;  // R20
         d.synced  = 1'b0;
         d.ack_low = 1'b0;
      end else if (scl_fall && q.synced) begin
         // Bytes joined mid-way are never counted
         d.cnt = nxt;
         if (nxt == `SBC_FALL_BIT1) begin
            d.icf = 1'b0;
         end
         if (nxt == `SBC_FALL_ACK) begin
            d.ack_low = part & ~q.tsel & ~q.acks;  // R13
         end
         if (nxt == `SBC_FALL_DONE) begin
            d.cnt     = `SBC_FALL_FIRST;
            d.ack_low = 1'b0;
            if (part) begin
               d.icf = 1'b1;
               d.irq_pending_flag = 1'b1;  // R19
            end
         end
      end

      // Own address matched by the address comparator
      if (addr_hit && q.synced) begin
         d.aas = 1'b1;
         d.slave_direction_flag = addr_rw;
         if (!addr_rw) begin
            d.irq_pending_flag = 1'b1;  // R19
         end
      end

      // Lost arbitration: leave master mode silently
      if (gen_lost) begin
         d.al   = 1'b1;
         d.irq_pending_flag  = 1'b1;  // R19
         d.msel = 1'b0;  // R8
      end

      // Read answer, one cycle after the strobe
      if (rd_en) begin
         case (addr)
            `SBC_OFS_CTRL: begin
               d.rd_data = {q.on, q.gate, q.msel, q.tsel, q.acks, 3'h0};  // R14
            end
            `SBC_OFS_STAT: begin
               d.rd_data = {q.icf, q.aas, q.busy, q.al, 1'b0, q.slave_direction_flag, q.irq_pending_flag, 1'b0};
            end
            default: begin
               d.rd_data = 8'h00;
            end
         endcase
      end

      // Disabled: hold the serial side in reset
      if (!q.on) begin
         d.busy       = 1'b0;  // R1
         d.irq_pending_flag        = 1'b0;
         d.aas        = 1'b0;
         d.al         = 1'b0;
         d.slave_direction_flag        = 1'b0;
         d.icf        = 1'b0;
         d.synced     = 1'b0;
         d.cnt        = 4'h0;
         d.ack_low    = 1'b0;
         d.cmd_start  = 1'b0;  // R5
         d.cmd_stop   = 1'b0;
         d.cmd_rstart = 1'b0;
      end

      // Gated request; pending flag itself is untouched by the gate
      d.irq = d.on & d.gate & d.irq_pending_flag;  // R6
   end

   // State register; every field clears on reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q <= '0;  // R21
      end else begin
         q <= d;
      end
   end

   assign rd_data = q.rd_data;
   assign irq     = q.irq;
   assign scl_out = q.pin_lo;
   assign sda_out = q.pin_lo;
endmodule
`default_nettype wire

// ---- testbench/sbc_ctrl_assertions.sv ----
// Checker of the control block ports: read answers, pin drive order.
// Assumes binding onto sbc_ctrl, one clock domain.
`include "sbc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sbc_ctrl_assertions (
   input wire logic                   clock,    // System clock
   input wire logic                   rst,      // Asynchronous reset
   input wire logic [`SBC_ADDR_W-1:0] addr,     // Register address
   input wire logic [7:0]             wr_data,  // Write data
   input wire logic                   wr_en,    // Write strobe
   input wire logic                   rd_en,    // Read strobe
   input wire logic [7:0]             rd_data,  // Read answer
   input wire logic                   scl_oe,   // Clock pull-down
   input wire logic                   sda_oe,   // Data pull-down
   input wire logic                   irq       // Interrupt request
);
   // Copy of software writes; hardware may still clear master select
   logic [7:0] sh_q;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sh_q <= 8'h00;
      end else if (wr_en && addr == `SBC_OFS_CTRL) begin
         sh_q <= wr_data;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data outside answer cycle");
   ctl_echo_a: assert property ($past(rd_en) && $past(addr) == `SBC_OFS_CTRL
      |-> {rd_data[7:6], rd_data[4:3]} == {$past(sh_q[7:6]), $past(sh_q[4:3])})
      else $error("control read differs from written value");
   rsvd_zero_a: assert property ($past(rd_en) && $past(addr) == `SBC_OFS_CTRL
      |-> rd_data[2:0] == 3'h0) else $error("repeat start or spare bits read set");
   irq_gate_a: assert property (irq |-> (sh_q[7] && sh_q[6])
      || ($past(sh_q[7]) && $past(sh_q[6]))) else $error("request without gate");
   off_quiet_a: assert property (!sh_q[7] && !$past(sh_q[7]) && !$past(sh_q[7], 2)
      |-> !scl_oe && !sda_oe) else $error("bus driven while disabled");
   start_order_a: assert property ($rose(scl_oe) |-> sda_oe && $past(sda_oe, 3))
      else $error("clock pulled before data on start");
   stop_order_a: assert property ($fell(scl_oe) && sda_oe |-> ##[3:6] !sda_oe)
      else $error("data not released after clock on stop");
   ack_drive_a: assert property ($rose(sda_oe) && !scl_oe && !sh_q[5]
      |-> !sh_q[3] && !sh_q[4]) else $error("acknowledge driven when not allowed");
   // Main scenarios reached
   cover property ($rose(scl_oe));
   cover property (irq);
   cover property ($rose(sda_oe) && !scl_oe && !sh_q[5]);
endmodule
`default_nettype wire

// ---- testbench/sbc_bus_peer.sv ----
// Other bus parties: pull-ups and a master that makes START, clocks
// bytes, samples the acknowledge and makes STOP.
// Assumes pull-low enables from the block, line released when low.
`timescale 1ns/10ps
`default_nettype none
module sbc_bus_peer (
   input  wire logic scl_oe,  // Block pulls clock low
   input  wire logic sda_oe,  // Block pulls data low
   output logic      scl_ln,  // Wired clock line
   output logic      sda_ln   // Wired data line
);
   logic p_scl = 1'b1;  // Own clock drive, 1 = released
   logic p_sda = 1'b1;  // Own data drive, 1 = released
   // Wired-AND with pull-ups: released lines float high
   assign scl_ln = ~scl_oe & p_scl;
   assign sda_ln = ~sda_oe & p_sda;
   // Data falls while clock high, then clock falls
   task automatic bus_start();
      #13 p_sda = 1'b0;
      #160 p_scl = 1'b0;
      #160;
   endtask
   // Eight bits and the ninth clock; data moves only while clock low
   task automatic send_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         p_sda = (i < 0) ? 1'b1 : d[i & 7];
         // Longer low phase before the ninth clock gives the receiver time to pull data
         if (i < 0) begin
            #160;
         end
         #160 p_scl = 1'b1;
         #150 ack = sda_ln;
         #10 p_scl = 1'b0;
      end
   endtask
   // Data rises while clock high
   task automatic bus_stop();
      p_sda = 1'b0;
      #80 p_scl = 1'b1;
      #160 p_sda = 1'b1;
      #160;
   endtask
endmodule
`default_nettype wire

// ---- testbench/sbc_ctrl_tb.sv ----
// Self-checking bench of the control block: register port, mode
// changes, arbitration, interrupt gate, slave acknowledge.
// Assumes the peer model and the checker bound below.
`include "sbc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sbc_ctrl_tb;
   localparam logic [`SBC_ADDR_W-1:0] CT = `SBC_OFS_CTRL;  // Control
   localparam logic [`SBC_ADDR_W-1:0] ST = `SBC_OFS_STAT;  // Status
   logic                   clock;       // 25 MHz clock
   logic                   rst;         // Reset
   logic [`SBC_ADDR_W-1:0] addr;        // Register address
   logic [7:0]             wr_data;     // Write data
   logic                   wr_en;       // Write strobe
   logic                   rd_en;       // Read strobe
   logic [7:0]             rd_data;     // Read answer
   logic                   addr_hit;    // Match pulse
   logic                   addr_rw;     // Match direction
   logic                   scl_ln;      // Wired lines
   logic                   sda_ln;
   logic                   scl_oe;      // Block pull-downs
   logic                   sda_oe;
   logic                   irq;         // Interrupt request
   int                     n_mismatch = 0;
   int                     n_checks = 0;
   sbc_ctrl sbc_ctrl_i (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .addr_hit(addr_hit),
      .addr_rw(addr_rw), .scl_in(scl_ln), .scl_out(), .scl_oe(scl_oe),
      .sda_in(sda_ln), .sda_out(), .sda_oe(sda_oe), .irq(irq));
   sbc_bus_peer sbc_bus_peer_i (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_ln(scl_ln),
      .sda_ln(sda_ln));
   // Clock, 40 ns period
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask
   // One-cycle write
   task automatic wr(input logic [`SBC_ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clock);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   // One-cycle read, answer judged under a mask
   task automatic rdc(input logic [`SBC_ADDR_W-1:0] a, input logic [7:0] m, e);
      @(posedge clock);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 chk(rd_data & m, e);
   endtask
   // Bounded wait for a pull-down enable to reach a level
   task automatic wait_oe(input bit clk_pin, input logic lvl);
      for (int i = 0; i < 40 && (clk_pin ? scl_oe : sda_oe) !== lvl; i++) begin
         @(posedge clock);
      end
      #1 chk({7'h00, clk_pin ? scl_oe : sda_oe}, {7'h00, lvl});
   endtask
   task automatic hit(input logic rw);
      @(posedge clock);
      addr_hit <= 1'b1;
      addr_rw <= rw;
      @(posedge clock);
      addr_hit <= 1'b0;
   endtask
   task automatic t_reset();
      rdc(CT, 8'hFF, `SBC_CTRL_RESET);
      rdc(ST, 8'hFF, 8'h00);
      rdc(10'h3FC, 8'hFF, 8'h00);
   endtask
   // Fields written while disabled do nothing on the bus
   task automatic t_off();
      wr(CT, 8'h7C);
      repeat (20) @(posedge clock);
      chk({5'h00, irq, scl_oe, sda_oe}, 8'h00);
      rdc(CT, 8'hFF, 8'h78);
      wr(CT, 8'h00);
   endtask
   // Start, repeated start and stop as master
   task automatic t_master();
      wr(CT, 8'h80);
      wr(CT, 8'hB0);
      wait_oe(0, 1'b1);
      wait_oe(1, 1'b1);
      rdc(ST, 8'h20, 8'h20);
      wr(CT, 8'hB4);
      wait_oe(1, 1'b0);
      wait_oe(1, 1'b1);
      rdc(CT, 8'hFF, 8'hB0);
      wr(CT, 8'h90);
      wait_oe(1, 1'b0);
      wait_oe(0, 1'b0);
      repeat (10) @(posedge clock);
      rdc(ST, 8'h20, 8'h00);
   endtask
   // Start on a busy bus loses; gate masks, pending stays
   task automatic t_arb();
      sbc_bus_peer_i.bus_start();
      wr(CT, 8'hA0);
      repeat (20) @(posedge clock);
      chk({6'h00, scl_oe, sda_oe}, 8'h00);
      rdc(CT, 8'hFF, 8'h80);
      rdc(ST, 8'h32, 8'h32);
      wr(CT, 8'hC0);
      repeat (2) @(posedge clock);
      #1 chk({7'h00, irq}, 8'h01);
      wr(CT, 8'h80);
      repeat (2) @(posedge clock);
      #1 chk({7'h00, irq}, 8'h00);
      rdc(ST, 8'h02, 8'h02);
      wr(ST, 8'h00);
      wr(CT, 8'h84);
      repeat (4) @(posedge clock);
      #1 chk({6'h00, scl_oe, sda_oe}, 8'h00);
      rdc(ST, 8'h12, 8'h12);
      wr(ST, 8'h00);
      sbc_bus_peer_i.bus_stop();
   endtask
   // Enabled in mid-transfer: a match before the next start is ignored
   task automatic t_late();
      wr(CT, 8'h00);
      sbc_bus_peer_i.bus_start();
      wr(CT, 8'hC0);
      hit(1'b0);
      rdc(ST, 8'h40, 8'h00);
      sbc_bus_peer_i.bus_stop();
   endtask
   // Addressed slave: acknowledge only when receiving and not suppressed
   task automatic t_slave();
      // Transmit chosen only for the read-direction match of the last pass
      logic [7:0] cv [3] = '{8'hC0, 8'hC8, 8'hD0};
      logic       ak;
      for (int k = 0; k < 3; k++) begin
         wr(CT, cv[k]);
         wr(ST, 8'h00);
         sbc_bus_peer_i.bus_start();
         hit(k == 2);
         rdc(ST, 8'h46, {5'h08, k == 2, k != 2, 1'b0});
         sbc_bus_peer_i.send_byte(8'h5A, ak);
         chk({7'h00, ak}, {7'h00, k != 0});
         repeat (6) @(posedge clock);
         rdc(ST, 8'h80, 8'h80);
         sbc_bus_peer_i.bus_stop();
      end
      wr(CT, 8'h80);
      rdc(ST, 8'h40, 8'h00);
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Main sequence after two reset cycles
   initial begin
      rst = 1'b1;
      addr = '0;
      wr_data = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr_hit = 1'b0;
      addr_rw = 1'b0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_off();
      t_master();
      t_arb();
      t_late();
      t_slave();
      complete_run();
   end
   // Watchdog, well past the expected run of some 20 us
   initial begin
      #400000;
      n_mismatch++;
      complete_run();
   end
endmodule
bind sbc_ctrl sbc_ctrl_assertions sbc_ctrl_assertions_i (.clock(clock), .rst(rst),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire
